/* File: hdl/reset_source_controller_consts.svh */
// Constants of the reset source controller: cause register bit
// positions, reset values and timing counts. Included by bare name.
`ifndef RESET_SOURCE_CONTROLLER_CONSTS_SVH
`define RESET_SOURCE_CONTROLLER_CONSTS_SVH

// Cause register bit positions
`define RSC_BIT_PIN       3'd0
`define RSC_BIT_POR       3'd1
`define RSC_BIT_CLK       3'd2
`define RSC_BIT_SOFT      3'd4
`define RSC_BIT_CMP_WDG   3'd5
`define RSC_BIT_MEM       3'd6

// Reset values
`define RSC_CAUSE_RST     8'h02
`define RSC_RESTART_ADDR  16'h0000

// Timing: clock period and power-on release delay
`define RSC_CLK_PERIOD_NS 100
`define RSC_POR_DELAY_US  300
`define RSC_POR_DELAY_CYC ((`RSC_POR_DELAY_US * 1000) / `RSC_CLK_PERIOD_NS)
// Internal reset stretch after any cause but power-on, in cycles
`define RSC_STRETCH_CYC   4'h4
// Missing-clock timeout, in enable ticks with no edge seen
`define RSC_MCLK_LIMIT    8'h40
// Watchdog prescale: system clock divided by twelve
`define RSC_WDG_DIV       4'hB

`endif

/* File: hdl/reset_source_controller_pkg.sv */
// Types shared by the reset source controller modules.
// Assumes the constants header is compiled alongside.
package reset_source_controller_pkg;

   // Sequencer states, Gray coded along hold -> stretch -> run
   typedef enum logic [1:0] {
      ST_HOLD    = 2'b00,
      ST_STRETCH = 2'b01,
      ST_RUN     = 2'b11
   } seq_state_t;

endpackage

/* File: hdl/reset_sync_2ff.sv */
// Two-flip-flop synchroniser for one level from outside the clock domain.
// Assumes an asynchronous active-low reset and a frozen state while ce is low.
`timescale 1ns/10ps
`default_nettype none

module reset_sync_2ff #(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic arst_n_i,
   input  wire logic ce_i,
   // Level in and out
   input  wire logic async_i,
   output logic      sync_o
);

   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   // Next values: first stage only feeds the second
   always_comb begin
      meta_d = ce_i ? async_i : meta_q;
      sync_d = ce_i ? meta_q : sync_q;
   end

   // Register the two stages
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;

endmodule

`default_nettype wire

/* File: hdl/reset_source_controller.sv */
// Reset source controller: gathers all reset causes, holds the core in
// reset, drives the open-drain reset pin and keeps the cause register.
// Assumes analog comparisons arrive as digital levels; pins are synchronised.
//
// Notes on behaviour
// - During power-up, hold core and drive pin low until supply is good.
// - Power-on or supply-monitor exit sets power-on flag at bit 1.
// - Every other reset cause clears the power-on flag.
// - Execution restarts at address zero after any reset.
// - Power-on disables supply monitor; other causes keep its state.
// - Enabled monitor seeing low supply drives pin low, holds core.
// - Writing one to bit 1 enables monitor as a reset source.
// - Supply-monitor reset releases without the power-on delay.
// - External low pin forces reset; exit sets pin flag bit 0.
// - Missing clock times out into reset; flag bit 2 reads one.
// - Writing bit 2 enables or disables the missing-clock detector.
// - Bit 5 enables comparator reset while positive below negative input.
// - After any reset watchdog is enabled, clocked by system clock/12.
// - Watchdog expiry resets and sets the flag at bit 5.
// - Program access above the user code limit causes a reset.
// - Memory error reset sets flag at bit 6.
// - Writing one to bit 4 forces reset; bit reads one afterwards.
// - Internal causes reset the core without driving the reset pin.
// - Monitor reset keeps data memory; power-on marks it undefined.
`timescale 1ns/10ps
`default_nettype none
`include "reset_source_controller_consts.svh"

module reset_source_controller
   import reset_source_controller_pkg::*;
#(
   parameter int POR_DELAY_CYC = `RSC_POR_DELAY_CYC
) (
   // Clock, reset and enable
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   input  wire logic        ce_i,
   // Supply and analog levels (asynchronous)
   input  wire logic        supply_ok_i,
   input  wire logic        comparator_out_i,
   // Reset pin, open drain, active low
   input  wire logic        reset_pin_n_i,
   output logic             reset_pin_o,
   output logic             reset_pin_oe_o,
   // Watchdog from the counter array (same clock)
   input  wire logic        watchdog_disable_i,
   input  wire logic        watchdog_expired_i,
   // Program memory access check (same clock)
   input  wire logic        mem_access_i,
   input  wire logic [15:0] mem_addr_i,
   input  wire logic [15:0] code_limit_i,
   // Clock activity seen by the detector (asynchronous)
   input  wire logic        clock_alive_i,
   // Cause register write port (same clock)
   input  wire logic        cause_wr_i,
   input  wire logic [7:0]  cause_wdata_i,
   // Status and core control
   output logic [7:0]       reset_cause_reg_o,
   output logic             core_reset_o,
   output logic [15:0]      restart_addr_o,
   output logic             supply_monitor_en_o,
   output logic             watchdog_enable_o,
   output logic             watchdog_tick_o,
   output logic             data_mem_undefined_o
);

   // Synchronised asynchronous inputs
   logic supply_ok_s;
   logic comp_s;
   logic pin_n_s;
   logic alive_s;
   logic [3:0] sync_in;
   logic [3:0] sync_out;

   // Per-channel reset level: the pin idles high, so its stage starts high
   // to keep a false low from looking like an external reset.
   localparam logic [3:0] SYNC_RST = 4'h4;

   assign sync_in = {clock_alive_i, reset_pin_n_i, comparator_out_i, supply_ok_i};

   // One synchroniser per asynchronous level
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sync
         reset_sync_2ff #(
            .RESET_VAL (SYNC_RST[g])
         ) u_sync (
            .clock_i  (clock_i),
            .arst_n_i (arst_n_i),
            .ce_i     (ce_i),
            .async_i  (sync_in[g]),
            .sync_o   (sync_out[g])
         );
      end
   endgenerate

   assign supply_ok_s = sync_out[0];
   assign comp_s      = sync_out[1];
   assign pin_n_s     = sync_out[2];
   assign alive_s     = sync_out[3];

   // State
   seq_state_t  state_q, state_d;
   logic [31:0] delay_q, delay_d;
   logic [7:0]  cause_q, cause_d;
   logic [7:0]  pend_q, pend_d;
   logic        mon_en_q, mon_en_d;
   logic        mclk_en_q, mclk_en_d;
   logic        cmp_en_q, cmp_en_d;
   logic        wdg_en_q, wdg_en_d;
   logic [3:0]  div_q, div_d;
   logic        tick_q, tick_d;
   logic [7:0]  mclk_cnt_q, mclk_cnt_d;
   logic        alive_prev_q, alive_prev_d;
   logic        soft_req_q, soft_req_d;
   logic        undef_q, undef_d;
   logic        por_q, por_d;
   logic        pin_drv_q, pin_drv_d;
   // Two-cycle history of our own pin drive; the synchronised pin lags
   // the wire by two edges, so our own low must not read as external.
   logic [1:0]  echo_q, echo_d;

   // Cause detection, combinational
   logic mon_low;
   logic pin_low;
   logic clk_lost;
   logic cmp_trip;
   logic wdg_trip;
   logic mem_trip;
   logic any_int;
   logic in_run;

   always_comb begin
      in_run   = (state_q == ST_RUN);
      mon_low  = !supply_ok_s && (mon_en_q || por_q);
      pin_low  = !pin_n_s && !pin_drv_q && (echo_q == 2'b00);
      clk_lost = mclk_en_q && (mclk_cnt_q >= `RSC_MCLK_LIMIT);
      cmp_trip = cmp_en_q && !comp_s && in_run;
      wdg_trip = wdg_en_q && watchdog_expired_i && in_run;
      mem_trip = mem_access_i && (mem_addr_i > code_limit_i) && in_run;
      any_int  = clk_lost || cmp_trip || wdg_trip || mem_trip || soft_req_q;
   end

   // Sequencer and cause latching
   always_comb begin
      state_d      = state_q;
      delay_d      = delay_q;
      pend_d       = pend_q;
      cause_d      = cause_q;
      mon_en_d     = mon_en_q;
      mclk_en_d    = mclk_en_q;
      cmp_en_d     = cmp_en_q;
      wdg_en_d     = wdg_en_q;
      soft_req_d   = 1'b0;
      undef_d      = undef_q;
      por_d        = por_q;
      pin_drv_d    = mon_low;
      // Collect causes while any is present, ahead of release
      if (mon_low || pin_low || any_int) begin
         state_d = ST_HOLD;
         if (mon_low) begin
            pend_d[`RSC_BIT_POR] = 1'b1;
         end
         if (pin_low) begin
            pend_d[`RSC_BIT_PIN] = 1'b1;
         end
         if (clk_lost) begin
            pend_d[`RSC_BIT_CLK] = 1'b1;
         end
         if (cmp_trip || wdg_trip) begin
            pend_d[`RSC_BIT_CMP_WDG] = 1'b1;
         end
         if (mem_trip) begin
            pend_d[`RSC_BIT_MEM] = 1'b1;
         end
         if (soft_req_q) begin
            pend_d[`RSC_BIT_SOFT] = 1'b1;
         end
         delay_d = por_q ? 32'(POR_DELAY_CYC)
                         : {28'h0, `RSC_STRETCH_CYC};
      end else begin
         case (state_q)
            ST_HOLD: begin
               state_d = ST_STRETCH;
            end
            ST_STRETCH: begin
               if (delay_q <= 32'd1) begin
                  state_d = ST_RUN;
                  // Latch flags: power-on excludes others
                  if (pend_q[`RSC_BIT_POR]) begin
                     cause_d = `RSC_CAUSE_RST;
                  end else begin
                     cause_d = pend_q;
                  end
                  if (por_q) begin
                     mon_en_d = 1'b0;
                  end
                  undef_d = por_q;
                  por_d   = 1'b0;
                  cmp_en_d  = 1'b0;
                  mclk_en_d = 1'b0;
                  wdg_en_d  = 1'b1;
                  pend_d    = 8'h00;
               end else begin
                  delay_d = delay_q - 32'd1;
               end
            end
            ST_RUN: begin
               if (watchdog_disable_i) begin
                  wdg_en_d = 1'b0;
               end
               if (cause_wr_i) begin
                  if (cause_wdata_i[`RSC_BIT_POR]) begin
                     mon_en_d = 1'b1;
                  end
                  mclk_en_d  = cause_wdata_i[`RSC_BIT_CLK];
                  cmp_en_d   = cause_wdata_i[`RSC_BIT_CMP_WDG];
                  soft_req_d = cause_wdata_i[`RSC_BIT_SOFT];
               end
            end
            default: begin
               state_d = ST_HOLD;
            end
         endcase
      end
   end

   // Own-drive echo mask
   always_comb begin
      echo_d = {echo_q[0], pin_drv_q};
   end

   // Missing-clock detector and watchdog prescaler
   always_comb begin
      alive_prev_d = alive_s;
      if (!mclk_en_q || (alive_s != alive_prev_q) || !in_run) begin
         mclk_cnt_d = 8'h00;
      end else if (mclk_cnt_q < `RSC_MCLK_LIMIT) begin
         mclk_cnt_d = mclk_cnt_q + 8'h01;
      end else begin
         mclk_cnt_d = mclk_cnt_q;
      end
      tick_d = 1'b0;
      if (!wdg_en_q || !in_run) begin
         div_d = 4'h0;
      end else if (div_q == `RSC_WDG_DIV) begin
         div_d  = 4'h0;
         tick_d = 1'b1;
      end else begin
         div_d = div_q + 4'h1;
      end
   end

   // Register all state; frozen while the clock enable is low
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q      <= ST_HOLD;
         delay_q      <= 32'h0000_0000;
         cause_q      <= `RSC_CAUSE_RST;
         pend_q       <= 8'h02;
         mon_en_q     <= 1'b0;
         mclk_en_q    <= 1'b0;
         cmp_en_q     <= 1'b0;
         wdg_en_q     <= 1'b1;
         div_q        <= 4'h0;
         tick_q       <= 1'b0;
         mclk_cnt_q   <= 8'h00;
         alive_prev_q <= 1'b0;
         soft_req_q   <= 1'b0;
         undef_q      <= 1'b1;
         por_q        <= 1'b1;
         pin_drv_q    <= 1'b1;
         echo_q       <= 2'b11;
      end else if (ce_i) begin
         state_q      <= state_d;
         delay_q      <= delay_d;
         cause_q      <= cause_d;
         pend_q       <= pend_d;
         mon_en_q     <= mon_en_d;
         mclk_en_q    <= mclk_en_d;
         cmp_en_q     <= cmp_en_d;
         wdg_en_q     <= wdg_en_d;
         div_q        <= div_d;
         tick_q       <= tick_d;
         mclk_cnt_q   <= mclk_cnt_d;
         alive_prev_q <= alive_prev_d;
         soft_req_q   <= soft_req_d;
         undef_q      <= undef_d;
         por_q        <= por_d;
         pin_drv_q    <= pin_drv_d;
         echo_q       <= echo_d;
      end
   end

   // Outputs: pin only driven for supply causes
   always_comb begin
      reset_pin_o          = 1'b0;
      reset_pin_oe_o       = pin_drv_q;
      core_reset_o         = !in_run;
      restart_addr_o       = `RSC_RESTART_ADDR;
      reset_cause_reg_o    = cause_q;
      supply_monitor_en_o  = mon_en_q;
      watchdog_enable_o    = wdg_en_q;
      watchdog_tick_o      = tick_q;
      data_mem_undefined_o = undef_q;
   end

endmodule

`default_nettype wire

/* File: sim/reset_pin_far_side.sv */
// Far side of the reset pin: pulled-up open-drain wire.
// Assumes the device drives its data low whenever its enable is high.
`timescale 1ns/10ps
`default_nettype none

module reset_pin_far_side (
   // External circuitry and device driver
   input  wire logic pull_low_i,
   input  wire logic dev_oe_i,
   input  wire logic dev_data_i,
   // Resolved wire level
   output logic      pin_n_o
);
   // Pull-up wins unless someone pulls low
   assign pin_n_o = !(pull_low_i || (dev_oe_i && !dev_data_i));
endmodule

`default_nettype wire

/* File: sim/reset_source_controller_checker.sv */
// Port-level assertions for the reset source controller.
// Assumes one clock domain; bound to every controller instance.
`timescale 1ns/10ps
`default_nettype none

module reset_source_controller_checker #(
   parameter int POR_DELAY_CYC = 8
) (
   // Clock, reset, inputs
   input wire logic        clock_i,
   input wire logic        arst_n_i,
   input wire logic        ce_i,
   input wire logic        supply_ok_i,
   input wire logic        reset_pin_n_i,
   input wire logic        watchdog_expired_i,
   input wire logic        mem_access_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [15:0] code_limit_i,
   input wire logic        cause_wr_i,
   input wire logic [7:0]  cause_wdata_i,
   // Watched outputs
   input wire logic        reset_pin_oe_o,
   input wire logic [7:0]  reset_cause_reg_o,
   input wire logic        core_reset_o,
   input wire logic [15:0] restart_addr_o,
   input wire logic        supply_monitor_en_o,
   input wire logic        watchdog_enable_o,
   input wire logic        watchdog_tick_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   // Accepted writes while running
   sequence s_soft_wr;
      cause_wr_i && cause_wdata_i[4] && ce_i && !core_reset_o;
   endsequence
   sequence s_mon_wr;
      cause_wr_i && cause_wdata_i[1] && ce_i && !core_reset_o;
   endsequence
   sequence s_hold4;
      core_reset_o [*4];
   endsequence

   // Cause checks
   a_soft_reset_internal: assert property (s_soft_wr |-> ##2 core_reset_o && !reset_pin_oe_o)
      else $error("soft write did not reset the core alone");
   a_monitor_enable_wr: assert property (s_mon_wr |=> supply_monitor_en_o)
      else $error("monitor not enabled by write");
   a_stretch_min: assert property ($rose(core_reset_o) |-> s_hold4)
      else $error("core reset shorter than stretch");
   a_power_flag_alone: assert property (reset_cause_reg_o[1] |-> reset_cause_reg_o == 8'h02)
      else $error("power-on flag shares the register");
   a_restart_zero: assert property (restart_addr_o == 16'h0000)
      else $error("restart address not zero");
   a_pin_low_reset: assert property ((!reset_pin_n_i && ce_i) [*4] |=> core_reset_o)
      else $error("low pin did not reset core");
   a_supply_low_reset: assert property ((!supply_ok_i && supply_monitor_en_o && ce_i) [*4]
      |=> core_reset_o && reset_pin_oe_o)
      else $error("low supply did not reset and drive pin");
   a_mem_error_reset: assert property (mem_access_i && mem_addr_i > code_limit_i && ce_i && !core_reset_o
      |-> ##[1:3] core_reset_o)
      else $error("bad code address did not reset");
   a_wdg_expiry_reset: assert property (watchdog_expired_i && watchdog_enable_o && ce_i && !core_reset_o
      |-> ##[1:3] core_reset_o)
      else $error("watchdog expiry did not reset");
   a_wdg_on_release: assert property ($fell(core_reset_o) |-> watchdog_enable_o)
      else $error("watchdog off at release");
   a_tick_gap: assert property (watchdog_tick_o |=> !watchdog_tick_o [*8])
      else $error("watchdog ticks too close");
endmodule

bind reset_source_controller reset_source_controller_checker #(.POR_DELAY_CYC(POR_DELAY_CYC)) i_chk (
   .clock_i, .arst_n_i, .ce_i, .supply_ok_i, .reset_pin_n_i, .watchdog_expired_i, .mem_access_i,
   .mem_addr_i, .code_limit_i, .cause_wr_i, .cause_wdata_i, .reset_pin_oe_o, .reset_cause_reg_o,
   .core_reset_o, .restart_addr_o, .supply_monitor_en_o, .watchdog_enable_o, .watchdog_tick_o);

`default_nettype wire

/* File: sim/tb_reset_source_controller.sv */
// Self-checking bench for the reset source controller.
// Assumes the checker is bound by its own file; power-on delay set to 8.
`timescale 1ns/10ps
`default_nettype none

module tb_reset_source_controller;
   logic clock_i, arst_n_i, ce_i, supply_ok_i, comparator_out_i, reset_pin_n_i, reset_pin_o;
   logic reset_pin_oe_o, watchdog_disable_i, watchdog_expired_i, mem_access_i, clock_alive_i;
   logic cause_wr_i, core_reset_o, supply_monitor_en_o, watchdog_enable_o, data_mem_undefined_o;
   logic [15:0] mem_addr_i, code_limit_i, restart_addr_o;
   logic [7:0]  cause_wdata_i, reset_cause_reg_o;
   logic        pull_low, alive_en, oe_seen;
   int          n_fail = 0, cmp_count = 0, cyc = 0, seed = 32'h59b0400b;
   int          order [7] = '{3, 2, 4, 5, 6, 1, 7};

   reset_source_controller #(.POR_DELAY_CYC(8)) i_dut (.clock_i, .arst_n_i, .ce_i, .supply_ok_i,
      .comparator_out_i, .reset_pin_n_i, .reset_pin_o, .reset_pin_oe_o, .watchdog_disable_i,
      .watchdog_expired_i, .mem_access_i, .mem_addr_i, .code_limit_i, .clock_alive_i, .cause_wr_i,
      .cause_wdata_i, .reset_cause_reg_o, .core_reset_o, .restart_addr_o, .supply_monitor_en_o,
      .watchdog_enable_o, .watchdog_tick_o(), .data_mem_undefined_o);
   reset_pin_far_side i_far (.pull_low_i(pull_low), .dev_oe_i(reset_pin_oe_o), .dev_data_i(reset_pin_o),
      .pin_n_o(reset_pin_n_i));

   // Clock, activity toggle and hang guard
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      if (alive_en) clock_alive_i <= ~clock_alive_i;
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         stop_test();
      end
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge clock_i);
      cause_wr_i <= 1'b1;
      cause_wdata_i <= d;
      @(posedge clock_i);
      cause_wr_i <= 1'b0;
   endtask
   // Wait for core reset level, noting any pin drive
   task automatic wait_rst(input logic v);
      while (core_reset_o !== v) begin
         oe_seen |= reset_pin_oe_o;
         @(negedge clock_i);
      end
   endtask
   // Expected cause byte per event kind
   function automatic logic [7:0] exp_cause(input int k);
      logic [7:0] t [1:7];
      t = '{8'h10, 8'h20, 8'h40, 8'h01, 8'h20, 8'h04, 8'h02};
      return t[k];
   endfunction

   // One reset event of kind k, then its results
   task automatic run(input int k);
      oe_seen = 1'b0;
      @(posedge clock_i);
      case (k)
         1: wr(8'h10);
         2: watchdog_expired_i <= 1'b1;
         3: begin
            mem_access_i <= 1'b1;
            mem_addr_i <= code_limit_i + 16'h0001 + {8'h00, 8'($random(seed))};
         end
         4: pull_low <= 1'b1;
         5: wr(8'h20);
         6: wr(8'h04);
         default: supply_ok_i <= 1'b0;
      endcase
      @(posedge clock_i);
      watchdog_expired_i <= 1'b0;
      mem_access_i <= 1'b0;
      comparator_out_i <= (k != 5);
      alive_en <= (k != 6);
      wait_rst(1'b1);
      oe_seen |= reset_pin_oe_o;
      repeat (6) @(posedge clock_i);
      pull_low <= 1'b0;
      comparator_out_i <= 1'b1;
      alive_en <= 1'b1;
      supply_ok_i <= 1'b1;
      wait_rst(1'b0);
      chk("cause", exp_cause(k), reset_cause_reg_o);
      if (k != 4) chk("pin drive", 16'(k == 7), oe_seen);
      chk("restart", 16'h0000, restart_addr_o);
      chk("watchdog", 16'h0001, watchdog_enable_o);
      $display("test %0d done", k);
      repeat (3) @(posedge clock_i);
   endtask

   initial begin
      {arst_n_i, supply_ok_i, pull_low, watchdog_disable_i, watchdog_expired_i} = '0;
      {mem_access_i, cause_wr_i, clock_alive_i, mem_addr_i, cause_wdata_i} = '0;
      {ce_i, comparator_out_i, alive_en} = 3'b111;
      code_limit_i = 16'h07FF;
      repeat (20) @(posedge clock_i);
      arst_n_i <= 1'b1;
      repeat (5) @(negedge clock_i);
      chk("pin at power-up", 16'h0001, reset_pin_oe_o);
      chk("core at power-up", 16'h0001, core_reset_o);
      @(posedge clock_i);
      supply_ok_i <= 1'b1;
      wait_rst(1'b0);
      chk("power cause", 16'h0002, reset_cause_reg_o);
      chk("monitor off", 16'h0000, supply_monitor_en_o);
      chk("watchdog on", 16'h0001, watchdog_enable_o);
      chk("memory undefined", 16'h0001, data_mem_undefined_o);
      $display("test power-up done");
      @(posedge clock_i);
      watchdog_disable_i <= 1'b1;
      code_limit_i <= 16'h0100 | (16'($random(seed)) & 16'h3FFF);
      @(posedge clock_i);
      watchdog_disable_i <= 1'b0;
      // Legal accesses, top address included
      for (int i = 0; i < 4; i++) begin
         @(posedge clock_i);
         mem_access_i <= 1'b1;
         mem_addr_i <= (i == 0) ? code_limit_i : (16'($random(seed)) & code_limit_i);
      end
      @(posedge clock_i);
      mem_access_i <= 1'b0;
      repeat (4) @(negedge clock_i);
      chk("legal access", 16'h0000, core_reset_o);
      chk("watchdog off", 16'h0000, watchdog_enable_o);
      // Frozen clock enable: a soft write must not be taken
      @(posedge clock_i);
      ce_i <= 1'b0;
      wr(8'h10);
      repeat (4) @(negedge clock_i);
      chk("frozen write", 16'h0000, core_reset_o);
      @(posedge clock_i);
      ce_i <= 1'b1;
      repeat (2) @(negedge clock_i);
      chk("after freeze", 16'h0000, core_reset_o);
      foreach (order[i]) begin
         if (order[i] == 1) begin
            wr(8'h02);
            repeat (2) @(negedge clock_i);
            wait_rst(1'b0);
            chk("monitor on", 16'h0001, supply_monitor_en_o);
         end
         run(order[i]);
         if (order[i] == 1) chk("monitor kept", 16'h0001, supply_monitor_en_o);
      end
      stop_test();
   end
endmodule

`default_nettype wire
